// ==== logic/fpds_defines.svh ====
`ifndef FPDS_DEFINES_SVH
`define FPDS_DEFINES_SVH

// register indices behind the indexed i/o data port
`define FPDS_IDX_CTRL1       8'h32
`define FPDS_IDX_CTRL2       8'h33
`define FPDS_IDX_UNLOCK      8'h34

// reset values
`define FPDS_CTRL1_RST       8'h20
`define FPDS_CTRL2_RST       8'h00
`define FPDS_UNLOCK_RST      8'h00
`define FPDS_RDATA_LOCKED    8'h00

// panel_control_one fields
`define FPDS_C1_PLASMA       7
`define FPDS_C1_FP_SEL       6
`define FPDS_C1_CRT_EN       5
`define FPDS_C1_PANEL_EN     4
`define FPDS_C1_CENT_SEL     3
`define FPDS_C1_CENT_EN      2
`define FPDS_C1_HDLY_HI      1
`define FPDS_C1_HDLY_LO      0

// panel_control_two fields
`define FPDS_C2_RES_HI       7
`define FPDS_C2_RES_LO       4

// panel_unlock_reg match: value 101xxxx in bits 6:0
`define FPDS_UNLOCK_MASK     8'h70
`define FPDS_UNLOCK_MATCH    8'h50

// frame pulse line numbers counted from the vsync rise
`define FPDS_FP_LINE_FIRST   2'h0
`define FPDS_FP_LINE_SECOND  2'h1
`define FPDS_LINE_SAT        2'h3

// hsync delay taps 0 through 7, 1 through 8 dot clocks
`define FPDS_HDLY_TAPS       8

`endif

// ==== logic/fpds_pkg.sv ====
package fpds_pkg;

  // panel width, one-hot
  typedef enum logic [3:0] {
    FPDS_W640   = 4'b0001,
    FPDS_W1280R = 4'b0010,
    FPDS_W1024  = 4'b0100,
    FPDS_W800   = 4'b1000
  } fpds_width_e;

  typedef struct packed {
    logic [7:0]  ctrl1;
    logic [7:0]  ctrl2;
    logic [7:0]  unlock;
    logic [7:0]  index;
    logic [7:0]  rdata;
    logic        vsPrev;
    logic        hsPrev;
    logic [1:0]  lineCnt;
    logic [2:0]  actDly;
    logic        actFpSel;
    logic        actWide;
    logic        halfSel;
    logic [3:0]  hold;
    logic [3:0]  upper;
    logic [3:0]  lower;
    logic        strobe;
    logic        fp;
    logic        panelHs;
    logic        crtEn;
    logic        panelEn;
    logic        autoCenter;
    logic        vertExpand;
    fpds_width_e width;
  } fpds_top_s;

endpackage : fpds_pkg

// ==== logic/fpds_hs_if.sv ====
`timescale 1ns/10ps
interface fpds_hs_if;
  logic       hsyncIn;
  logic [2:0] delaySel;
  logic       hsyncDly;

  modport master (output hsyncIn, output delaySel, input hsyncDly);
  modport delay  (input hsyncIn, input delaySel, output hsyncDly);
endinterface : fpds_hs_if

// ==== logic/fpds_hsync_delay.sv ====
`timescale 1ns/10ps
`include "fpds_defines.svh"
module fpds_hsync_delay #(
  parameter int TAPS = `FPDS_HDLY_TAPS
) (
  input  wire logic clk,   // dot clock
  input  wire logic rst,   // sync reset, high
  fpds_hs_if.delay  hs     // hsync in, tap select, delayed hsync
);

  typedef struct packed {
    logic [TAPS-2:0] sh;
    logic            out;
  } fpds_dly_s;

  fpds_dly_s st_r;
  fpds_dly_s st_nxt;
  logic [TAPS-1:0] taps;

  // tap 0 is the undelayed input; one register stage is common to all taps
  always_comb begin
    taps      = {st_r.sh, hs.hsyncIn};
    st_nxt    = st_r;
    st_nxt.sh = taps[TAPS-2:0];
    st_nxt.out = taps[hs.delaySel];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hs.hsyncDly = st_r.out;

endmodule : fpds_hsync_delay

// ==== logic/fpds_select.sv ====
`timescale 1ns/10ps
`include "fpds_defines.svh"
module fpds_select (
  input  wire logic       clk,            // video dot clock, 20 MHz
  input  wire logic       rst,            // sync reset, high
  input  wire logic       ioIdxWr,        // write strobe, index port
  input  wire logic       ioDataWr,       // write strobe, data port
  input  wire logic       ioDataRd,       // read strobe, data port
  input  wire logic [7:0] ioWdata,        // write data
  output logic      [7:0] ioRdata,        // read data, valid cycle after strobe
  input  wire logic       hsyncIn,        // crtc hsync, same clock
  input  wire logic       vsyncIn,        // crtc vsync, same clock
  input  wire logic [3:0] pixelIn,        // panel pixel, one per clock
  input  wire logic [7:0] palIdxIn,       // palette index for external dac
  output logic      [3:0] upperPanelData, // upper_panel_data
  output logic      [3:0] lowerPanelData, // lower_panel_data
  output logic            panelStrobe,    // panel data valid
  output logic            panelHsync,     // hsync to panel, one clock late, no tap delay
  output logic            picHsync,       // hsync for picture position
  output logic            framePulse,     // frame_pulse
  output logic            crtEnable,      // crt output on
  output logic            panelEnable,    // panel is main display
  output logic            autoCenterOn,   // auto-centering active
  output logic            vertExpandOn,   // vertical expansion active
  output logic      [3:0] panelWidth      // one-hot width select
);

  fpds_pkg::fpds_top_s st_r;
  fpds_pkg::fpds_top_s st_nxt;
  fpds_hs_if           hsBus ();
  logic                unlocked;
  logic                vsRise;
  logic                hsRise;
  logic                crtOnly;
  logic [2:0]          dlyReq;

  fpds_hsync_delay #(
    .TAPS (`FPDS_HDLY_TAPS)
  ) u_hdly (
    .clk (clk),
    .rst (rst),
    .hs  (hsBus.delay)
  );

  function automatic fpds_pkg::fpds_width_e width_of(input logic hi, input logic lo);
    fpds_pkg::fpds_width_e w;
    if (!hi && !lo) begin
      w = fpds_pkg::FPDS_W640;
    end else if (!hi && lo) begin
      w = fpds_pkg::FPDS_W1280R;
    end else if (hi && !lo) begin
      w = fpds_pkg::FPDS_W1024;
    end else begin
      w = fpds_pkg::FPDS_W800;
    end
    return w;
  endfunction : width_of

  always_comb begin
    unlocked = (st_r.unlock & `FPDS_UNLOCK_MASK) == `FPDS_UNLOCK_MATCH;
    vsRise   = vsyncIn && !st_r.vsPrev;
    hsRise   = hsyncIn && !st_r.hsPrev;
    dlyReq   = {st_r.ctrl1[`FPDS_C1_PLASMA], st_r.ctrl1[`FPDS_C1_HDLY_HI],
                st_r.ctrl1[`FPDS_C1_HDLY_LO]};
    crtOnly  = st_r.ctrl1[`FPDS_C1_CRT_EN] && !st_r.ctrl1[`FPDS_C1_PANEL_EN];

    st_nxt        = st_r;
    st_nxt.vsPrev = vsyncIn;
    st_nxt.hsPrev = hsyncIn;

    // host register access
    if (ioIdxWr) begin
      st_nxt.index = ioWdata;
    end
    if (ioDataWr) begin
      if (st_r.index == `FPDS_IDX_UNLOCK) begin
        st_nxt.unlock = ioWdata;
      end else if (st_r.index == `FPDS_IDX_CTRL1 && unlocked) begin
        st_nxt.ctrl1 = ioWdata;
      end else if (st_r.index == `FPDS_IDX_CTRL2 && unlocked) begin
        st_nxt.ctrl2 = ioWdata;
      end
    end
    if (ioDataRd) begin
      if (st_r.index == `FPDS_IDX_CTRL1 && unlocked) begin
        st_nxt.rdata = st_r.ctrl1;
      end else if (st_r.index == `FPDS_IDX_CTRL2 && unlocked) begin
        st_nxt.rdata = st_r.ctrl2;
      end else begin
        // unlock register is write only; locked or foreign index reads a constant
        st_nxt.rdata = `FPDS_RDATA_LOCKED;
      end
    end

    // static selections follow the register directly
    st_nxt.crtEn      = st_r.ctrl1[`FPDS_C1_CRT_EN];
    st_nxt.panelEn    = st_r.ctrl1[`FPDS_C1_PANEL_EN];
    st_nxt.autoCenter = st_r.ctrl1[`FPDS_C1_CENT_EN] && !st_r.ctrl1[`FPDS_C1_CENT_SEL];
    st_nxt.vertExpand = st_r.ctrl1[`FPDS_C1_CENT_EN] && st_r.ctrl1[`FPDS_C1_CENT_SEL];
    st_nxt.width      = width_of(st_r.ctrl2[`FPDS_C2_RES_HI], st_r.ctrl2[`FPDS_C2_RES_LO]);

    // timing choices only change at frame start so no line is cut short
    if (vsRise) begin
      st_nxt.actDly   = dlyReq;
      st_nxt.actFpSel = st_r.ctrl1[`FPDS_C1_FP_SEL];
      st_nxt.actWide  = st_r.ctrl1[`FPDS_C1_PLASMA];
    end

    // line counter from vsync rise, saturates at 3 after the third hsync rise
    if (vsRise) begin
      st_nxt.lineCnt = `FPDS_FP_LINE_FIRST;
    end else if (hsRise && st_r.lineCnt != `FPDS_LINE_SAT) begin
      st_nxt.lineCnt = st_r.lineCnt + 2'h1;
    end
    if (st_nxt.actFpSel) begin
      st_nxt.fp = st_nxt.lineCnt == `FPDS_FP_LINE_SECOND;
    end else begin
      st_nxt.fp = st_nxt.lineCnt == `FPDS_FP_LINE_FIRST;
    end
    if (!st_r.ctrl1[`FPDS_C1_PANEL_EN]) begin
      st_nxt.fp = 1'b0;
    end

    // panel hsync takes one register stage and never the selected tap delay
    st_nxt.panelHs = hsyncIn && st_r.ctrl1[`FPDS_C1_PANEL_EN];

    // panel data path
    if (crtOnly) begin
      st_nxt.upper   = palIdxIn[7:4];
      st_nxt.lower   = palIdxIn[3:0];
      st_nxt.strobe  = 1'b1;
      st_nxt.halfSel = 1'b0;
    end else if (!st_r.ctrl1[`FPDS_C1_PANEL_EN]) begin
      st_nxt.upper   = 4'h0;
      st_nxt.lower   = 4'h0;
      st_nxt.strobe  = 1'b0;
      st_nxt.halfSel = 1'b0;
    end else if (!st_r.actWide) begin
      st_nxt.upper   = pixelIn;
      st_nxt.lower   = 4'h0;
      st_nxt.strobe  = 1'b1;
      st_nxt.halfSel = 1'b0;
    end else if (hsRise || !st_r.halfSel) begin
      // pairs restart at each line so a pixel never straddles two lines
      st_nxt.hold    = pixelIn;
      st_nxt.halfSel = 1'b1;
      st_nxt.strobe  = 1'b0;
    end else begin
      st_nxt.upper   = st_r.hold;
      st_nxt.lower   = pixelIn;
      st_nxt.strobe  = 1'b1;
      st_nxt.halfSel = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r          <= '0;
      st_r.ctrl1    <= `FPDS_CTRL1_RST;
      st_r.ctrl2    <= `FPDS_CTRL2_RST;
      st_r.unlock   <= `FPDS_UNLOCK_RST;
      st_r.rdata    <= `FPDS_RDATA_LOCKED;
      st_r.crtEn    <= 1'b1;
      st_r.lineCnt  <= `FPDS_LINE_SAT;
      st_r.width    <= fpds_pkg::FPDS_W640;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hsBus.hsyncIn  = hsyncIn;
  assign hsBus.delaySel = st_r.actDly;

  assign ioRdata        = st_r.rdata;
  assign upperPanelData = st_r.upper;
  assign lowerPanelData = st_r.lower;
  assign panelStrobe    = st_r.strobe;
  assign panelHsync     = st_r.panelHs;
  assign picHsync       = hsBus.hsyncDly;
  assign framePulse     = st_r.fp;
  assign crtEnable      = st_r.crtEn;
  assign panelEnable    = st_r.panelEn;
  assign autoCenterOn   = st_r.autoCenter;
  assign vertExpandOn   = st_r.vertExpand;
  assign panelWidth     = st_r.width;

endmodule : fpds_select

// ==== verification/fpds_select_checker.sv ====
`timescale 1ns/10ps
module fpds_select_checker (
  input wire logic       clk,            // clock
  input wire logic       rst,            // reset
  input wire logic       hsyncIn,        // crtc hsync
  input wire logic [7:0] palIdxIn,       // dac index
  input wire logic [3:0] upperPanelData, // upper lane
  input wire logic [3:0] lowerPanelData, // lower lane
  input wire logic       panelStrobe,    // lane valid
  input wire logic       panelHsync,     // panel hsync
  input wire logic       picHsync,       // shifted hsync
  input wire logic       framePulse,     // frame pulse
  input wire logic       crtEnable,      // crt on
  input wire logic       panelEnable,    // panel on
  input wire logic       autoCenterOn,   // centering
  input wire logic       vertExpandOn,   // expansion
  input wire logic [3:0] panelWidth      // width
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence crtOnly;
    crtEnable && !panelEnable;
  endsequence
  sequence hsRise;
    !hsyncIn ##1 hsyncIn;
  endsequence
  crt_pixel_bus_a: assert property (
    !$past(rst) ##0 crtOnly |-> panelStrobe && {upperPanelData, lowerPanelData} == $past(palIdxIn))
    else $error("crt pixel bus wrong");
  panel_hsync_a: assert property (
    panelEnable && $past(panelEnable) |-> panelHsync == $past(hsyncIn))
    else $error("panel hsync not one cycle late");
  pic_delay_a: assert property (
    hsRise |-> ##[1:8] picHsync)
    else $error("shifted hsync late");
  pic_quiet_a: assert property (
    (!hsyncIn)[*8] |=> !picHsync)
    else $error("shifted hsync without cause");
  width_onehot_a: assert property (
    $onehot(panelWidth))
    else $error("width not one-hot");
  cent_exclusive_a: assert property (
    !(autoCenterOn && vertExpandOn))
    else $error("centering and expansion both on");
  dark_outputs_a: assert property (
    !$past(rst) && !crtEnable && !panelEnable |-> !panelStrobe && {upperPanelData, lowerPanelData} == 8'h00)
    else $error("lanes active with no display");
  fp_panel_off_a: assert property (
    !panelEnable && !$past(panelEnable) |-> !framePulse && !panelHsync)
    else $error("panel timing while disabled");
endmodule : fpds_select_checker

bind fpds_select fpds_select_checker fpds_select_checker_inst (.clk(clk), .rst(rst), .hsyncIn(hsyncIn),
  .palIdxIn(palIdxIn), .upperPanelData(upperPanelData), .lowerPanelData(lowerPanelData),
  .panelStrobe(panelStrobe), .panelHsync(panelHsync), .picHsync(picHsync), .framePulse(framePulse),
  .crtEnable(crtEnable), .panelEnable(panelEnable), .autoCenterOn(autoCenterOn),
  .vertExpandOn(vertExpandOn), .panelWidth(panelWidth));

// ==== verification/fpds_panel_model.sv ====
`timescale 1ns/10ps
module fpds_panel_model (
  input  wire logic       clk,       // dot clock
  input  wire logic [3:0] upperData, // upper lane
  input  wire logic [3:0] lowerData, // lower lane
  input  wire logic       strobe,    // lane valid
  output int              strobeCnt, // beats taken
  output logic      [7:0] lastPair   // last beat
);
  initial strobeCnt = 0;
  // panel latches only on a valid beat
  always @(posedge clk) if (strobe === 1'h1) begin
    strobeCnt <= strobeCnt + 1;
    lastPair  <= {upperData, lowerData};
  end
endmodule : fpds_panel_model

// ==== verification/fpds_select_test.sv ====
`timescale 1ns/10ps
module fpds_select_test;
  logic clk = 0, rst = 1, ioIdxWr = 0, ioDataWr = 0, ioDataRd = 0, hsyncIn = 0, vsyncIn = 0;
  logic [7:0] ioWdata = 8'h00, palIdxIn = 8'ha5, ioRdata, lastPair, rv;
  logic [3:0] pixelIn = 4'h5, upperPanelData, lowerPanelData, panelWidth;
  logic panelStrobe, panelHsync, picHsync, framePulse, crtEnable, panelEnable, autoCenterOn, vertExpandOn;
  int strobeCnt, fails = 0, checkCount = 0;
  always #25 clk = ~clk;
  // moving pixel stream so lane order and pairing phase show in the data
  always @(posedge clk) pixelIn <= pixelIn + 4'h1;
  fpds_select fpds_select_inst (.clk, .rst, .ioIdxWr, .ioDataWr, .ioDataRd, .ioWdata, .ioRdata, .hsyncIn,
    .vsyncIn, .pixelIn, .palIdxIn, .upperPanelData, .lowerPanelData, .panelStrobe, .panelHsync, .picHsync,
    .framePulse, .crtEnable, .panelEnable, .autoCenterOn, .vertExpandOn, .panelWidth);
  fpds_panel_model fpds_panel_model_inst (.clk, .upperData(upperPanelData), .lowerData(lowerPanelData),
    .strobe(panelStrobe), .strobeCnt, .lastPair);
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checkCount++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask : chk
  task wr(input logic [7:0] i, input logic [7:0] d);
    @(posedge clk) begin ioIdxWr <= 1'h1; ioWdata <= i; end
    @(posedge clk) begin ioIdxWr <= 1'h0; ioDataWr <= 1'h1; ioWdata <= d; end
    @(posedge clk) ioDataWr <= 1'h0;
  endtask : wr
  task rd(input logic [7:0] i);
    @(posedge clk) begin ioIdxWr <= 1'h1; ioWdata <= i; end
    @(posedge clk) begin ioIdxWr <= 1'h0; ioDataRd <= 1'h1; end
    @(posedge clk) ioDataRd <= 1'h0;
    @(posedge clk) #1 rv = ioRdata;
  endtask : rd
  task vs;
    @(posedge clk) vsyncIn <= 1'h1;
    @(posedge clk) vsyncIn <= 1'h0;
  endtask : vs
  task hs;
    @(posedge clk) hsyncIn <= 1'h1;
    @(posedge clk) hsyncIn <= 1'h0;
  endtask : hs
  function automatic logic [7:0] flags;
    return {crtEnable, panelEnable, autoCenterOn, vertExpandOn, panelWidth};
  endfunction : flags
  task tLock;
    #1 chk("reset flags", 8'h81, flags());
    wr(8'h32, 8'h1c);
    rd(8'h32);
    chk("locked read", 8'h00, rv);
    chk("locked flags", 8'h81, flags());
  endtask : tLock
  task automatic tCtrl;
    logic [7:0] cv[4] = '{8'h1c, 8'h14, 8'h30, 8'h18};
    logic [7:0] ev[4] = '{8'h51, 8'h61, 8'hc1, 8'h41};
    wr(8'h34, 8'hd0);
    for (int k = 0; k < 4; k++) begin
      wr(8'h32, cv[k]);
      rd(8'h32);
      chk("ctrl1", cv[k], rv);
      chk("flags", ev[k], flags());
    end
    rd(8'h34);
    chk("unlock read", 8'h00, rv);
  endtask : tCtrl
  task automatic tRes;
    logic [7:0] cv[4] = '{8'h68, 8'h30, 8'h80, 8'h98};
    for (int k = 0; k < 4; k++) begin
      wr(8'h33, cv[k]);
      rd(8'h33);
      chk("ctrl2", cv[k], rv);
      chk("width", 8'h01 << k, {4'h0, panelWidth});
    end
    wr(8'h34, 8'h40);
    rd(8'h33);
    chk("relocked", 8'h00, rv);
    wr(8'h34, 8'h50);
  endtask : tRes
  task tCrt;
    wr(8'h32, 8'h20);
    repeat (2) @(posedge clk);
    #1 chk("crt lanes", palIdxIn, {upperPanelData, lowerPanelData});
    wr(8'h32, 8'h00);
    repeat (2) @(posedge clk);
    #1 chk("dark", 8'h00, {3'h0, panelStrobe, upperPanelData});
  endtask : tCrt
  task tDelay;
    int c;
    logic ph;
    for (int n = 0; n < 8; n++) begin
      wr(8'h32, {n[2], 5'h04, n[1:0]});
      vs;
      repeat (3) @(posedge clk);
      @(posedge clk) hsyncIn <= 1'h1;
      c = 0;
      do begin
        @(posedge clk) #1 c++;
        if (c == 1) ph = panelHsync;
      end while (!picHsync && c < 20);
      @(posedge clk) hsyncIn <= 1'h0;
      chk("hsync delay", 8'(n + 1), 8'(c));
      chk("panel hsync", 8'h01, {7'h0, ph});
      repeat (12) @(posedge clk);
    end
    // new delay bits without a vsync rise: the eight-clock delay must still hold
    wr(8'h32, 8'h10);
    @(posedge clk) hsyncIn <= 1'h1;
    repeat (7) @(posedge clk);
    #1 chk("held delay", 8'h00, {7'h0, picHsync});
    @(posedge clk) hsyncIn <= 1'h0;
  endtask : tDelay
  task tFrame;
    int fl;
    for (int s = 0; s < 2; s++) begin
      wr(8'h32, s ? 8'h50 : 8'h10);
      vs;
      fl = 9;
      for (int i = 0; i < 3; i++) begin
        repeat (6) @(posedge clk) #1 if (framePulse && fl == 9) fl = i;
        hs;
      end
      chk("fp line", 8'(s), 8'(fl));
    end
  endtask : tFrame
  task tPix;
    int s0;
    for (int w = 0; w < 2; w++) begin
      wr(8'h32, w ? 8'h90 : 8'h10);
      vs;
      hs;
      repeat (3) @(posedge clk);
      #1 s0 = strobeCnt;
      repeat (8) @(posedge clk);
      #1 chk("beats", w ? 8'h04 : 8'h08, 8'(strobeCnt - s0));
      chk("pair", w ? {pixelIn - 4'h4, pixelIn - 4'h3} : {pixelIn - 4'h2, 4'h0}, lastPair);
    end
  endtask : tPix
  task stopTest;
    if (fails == 0 && checkCount > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stopTest
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    tLock;
    tCtrl;
    tRes;
    tCrt;
    tDelay;
    tFrame;
    tPix;
    stopTest;
  end
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    stopTest;
  end
endmodule : fpds_select_test
